// File: core/ulmc_pkg.sv
/*
  Package for the line format and modem control block: register offsets,
  field positions, reset values and timing constants.
  Assumes an 8-bit register bank addressed by a 3-bit location index.
*/
package ulmc_pkg;
  // Register locations
  localparam logic [2:0] ULMC_OFS_ENHF = 3'h2;
  localparam logic [2:0] ULMC_OFS_LFR = 3'h3;
  localparam logic [2:0] ULMC_OFS_MLC = 3'h4;
  localparam logic [2:0] ULMC_OFS_STAT = 3'h6;
  localparam logic [2:0] ULMC_OFS_SCR = 3'h7;
  // Access key for the enhanced bank
  localparam logic [7:0] ULMC_LFR_EBANK_KEY = 8'hbf;
  // Line format fields
  localparam int ULMC_LFR_BANK = 7;
  localparam int ULMC_LFR_FORCE = 5;
  localparam int ULMC_LFR_PTYPE = 4;
  localparam int ULMC_LFR_PEN = 3;
  localparam int ULMC_LFR_STOP = 2;
  localparam int ULMC_LFR_WLEN_HI = 1;
  localparam int ULMC_LFR_WLEN_LO = 0;
  localparam logic [7:0] ULMC_LFR_RESET = 8'h1d;
  // Modem line control fields
  localparam int ULMC_MLC_PRESC = 7;
  localparam int ULMC_MLC_IRDA = 6;
  localparam int ULMC_MLC_XANY = 5;
  localparam int ULMC_MLC_LOOP = 4;
  localparam int ULMC_MLC_AUX2 = 3;
  localparam int ULMC_MLC_AUX1 = 2;
  localparam int ULMC_MLC_RTS = 1;
  localparam int ULMC_MLC_DTR = 0;
  localparam logic [7:0] ULMC_MLC_RESET = 8'h00;
  // Bits that need the enhanced-function enable to change
  localparam logic [7:0] ULMC_MLC_GATED = 8'hec;
  // Enhanced feature fields
  localparam int ULMC_ENHF_ARTS = 6;
  localparam int ULMC_ENHF_ENH = 4;
  localparam logic [7:0] ULMC_ENHF_RESET = 8'h00;
  // Prescaler ratio when divided
  localparam int ULMC_PRESC_DIV = 4;
  localparam logic [1:0] ULMC_PRESC_LAST = 2'(ULMC_PRESC_DIV - 1);
endpackage : ulmc_pkg

// File: core/ulmc_prescaler.sv
/*
  Clock prescaler: one-cycle enable at full rate or one in four cycles.
  Assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
module ulmc_prescaler
  import ulmc_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Control
  input wire logic divide_in,
  // Enable to the baud logic
  output logic tick_out
);
  logic [1:0] count_r;
  wire logic wrap = (count_r == ULMC_PRESC_LAST);

  always_ff @(posedge clk_in) begin
    if (reset_in || wrap) begin
      count_r <= 2'h0;
    end else begin
      count_r <= count_r + 2'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= divide_in ? wrap : 1'b1;
    end
  end
endmodule : ulmc_prescaler

// File: core/ulmc_line_modem_ctrl.sv
/*
  Line format and modem line control registers of a bridge UART, with the
  frame-format decode, parity generation, loopback routing and bank select.
  Assumes a register port of location, write strobe and data from the host
  serial interface, and a transmitter that asks for parity of its data.
*/
//
// Summary of operation
// RULE_01 - Forced parity: one if type 0, zero if 1
// RULE_02 - Unforced parity: odd for type 0, even 1
// RULE_03 - Parity bit only while parity enabled
// RULE_04 - Stop select: 1, else 1.5 or 2 bits
// RULE_05 - Word length field picks 5 to 8 bits
// RULE_06 - Prescaler bit: undivided or divide by four
// RULE_07 - Infrared enable routes data through encoder
// RULE_08 - Any received character resumes halted transmitter
// RULE_09 - Store resume character unless flow-control character
// RULE_10 - Loopback joins transmit to receive, status 4,5
// RULE_11 - Aux two has no pin; loopback carrier
// RULE_12 - Aux one selects bank; loopback ring status
// RULE_13 - Request-to-send bit drives pin inverted
// RULE_14 - Auto flow control overrides request-to-send bit
// RULE_15 - Terminal-ready bit drives configured pin inverted
// RULE_16 - Gated control bits need enhanced enable
// RULE_17 - Control register needs bank bit clear, resets 00
// RULE_18 - Enhanced enable gates extended fields, sleep
// RULE_19 - Parity covers configured data bits only
`timescale 1ns/1ps
module ulmc_line_modem_ctrl
  import ulmc_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Register port
  input wire logic [2:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // Transmit path
  input wire logic [7:0] tx_data_in,
  input wire logic tx_serial_in,
  input wire logic tx_ir_in,
  output logic tx_pin_out,
  output logic parity_en_out,
  output logic parity_bit_out,
  output logic [3:0] data_bits_out,
  output logic [2:0] stop_halves_out,
  output logic baud_tick_out,
  // Receive path
  input wire logic rx_pin_in,
  input wire logic rx_ir_in,
  output logic rx_serial_out,
  // Flow control
  input wire logic tx_halted_in,
  input wire logic rx_char_in,
  input wire logic rx_is_flow_char_in,
  input wire logic rx_swflow_en_in,
  input wire logic auto_rts_level_in,
  output logic tx_resume_out,
  output logic rx_store_out,
  // Modem pins and status
  input wire logic cts_n_in,
  input wire logic dsr_n_in,
  input wire logic ri_n_in,
  input wire logic cd_n_in,
  input wire logic dtr_pin_sel_in,
  output logic rts_n_out,
  output logic dtr_n_out,
  output logic [7:0] modem_status_out,
  // Mode outputs
  output logic ir_mode_out,
  output logic loopback_out,
  output logic thresh_bank_out,
  output logic enh_enable_out,
  output logic sleep_allow_out
);
  logic [7:0] line_format_register_r;
  logic [7:0] modem_line_control_register_r;
  logic [7:0] enhanced_feature_register_r;
  logic [7:0] scratch_register_r;

  // Bank decode
  wire logic bank_bit = line_format_register_r[ULMC_LFR_BANK];
  wire logic ebank = (line_format_register_r == ULMC_LFR_EBANK_KEY);
  wire logic enh = enhanced_feature_register_r[ULMC_ENHF_ENH];
  wire logic loop = modem_line_control_register_r[ULMC_MLC_LOOP];
  wire logic aux1 = modem_line_control_register_r[ULMC_MLC_AUX1];
  wire logic aux2 = modem_line_control_register_r[ULMC_MLC_AUX2];
  wire logic wr_lfr = reg_wr_in && (reg_addr_in == ULMC_OFS_LFR);
  wire logic wr_mlc = reg_wr_in && !bank_bit && (reg_addr_in == ULMC_OFS_MLC); // [RULE_17]
  wire logic wr_enhf = reg_wr_in && ebank && (reg_addr_in == ULMC_OFS_ENHF);
  wire logic wr_scr = reg_wr_in && !bank_bit && !(aux1 && !loop)
    && (reg_addr_in == ULMC_OFS_SCR); // [RULE_12]

  // Gated bits keep their old value without enhanced enable
  wire logic [7:0] mlc_keep = enh ? 8'h00 : ULMC_MLC_GATED; // [RULE_16] [RULE_18]
  wire logic [7:0] mlc_nxt = (modem_line_control_register_r & mlc_keep)
    | (reg_wdata_in & ~mlc_keep); // [RULE_16]

  // Register bank
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      line_format_register_r <= ULMC_LFR_RESET;
    end else if (wr_lfr) begin
      line_format_register_r <= reg_wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      modem_line_control_register_r <= ULMC_MLC_RESET; // [RULE_17]
    end else if (wr_mlc) begin
      modem_line_control_register_r <= mlc_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      enhanced_feature_register_r <= ULMC_ENHF_RESET;
    end else if (wr_enhf) begin
      enhanced_feature_register_r <= reg_wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      scratch_register_r <= 8'h00;
    end else if (wr_scr) begin
      scratch_register_r <= reg_wdata_in;
    end
  end

  // Frame format decode
  wire logic [1:0] wlen = line_format_register_r[ULMC_LFR_WLEN_HI:ULMC_LFR_WLEN_LO];
  wire logic [3:0] nbits = 4'h5 + {2'h0, wlen}; // [RULE_05]
  wire logic two_stop = line_format_register_r[ULMC_LFR_STOP];
  wire logic [2:0] halves = !two_stop ? 3'h2 : (wlen == 2'h0) ? 3'h3 : 3'h4; // [RULE_04]
  wire logic pen = line_format_register_r[ULMC_LFR_PEN];
  wire logic ptype = line_format_register_r[ULMC_LFR_PTYPE];
  wire logic pforce = line_format_register_r[ULMC_LFR_FORCE];

  // Parity over active data bits only
  logic [7:0] data_mask;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_mask
      assign data_mask[gi] = (4'(gi) < nbits); // [RULE_19]
    end
  endgenerate
  wire logic xor_data = ^(tx_data_in & data_mask); // [RULE_19]
  // Odd parity makes total ones odd: bit = ~xor
  wire logic calc_par = ptype ? xor_data : ~xor_data; // [RULE_02]
  wire logic force_par = ~ptype; // [RULE_01]
  wire logic par_bit = pen & (pforce ? force_par : calc_par); // [RULE_03]

  // Prescaler
  ulmc_prescaler u_presc (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .divide_in(modem_line_control_register_r[ULMC_MLC_PRESC]), // [RULE_06]
    .tick_out(baud_tick_out)
  );

  // Line and infrared routing
  wire logic ir = modem_line_control_register_r[ULMC_MLC_IRDA];
  wire logic tx_line = ir ? tx_ir_in : tx_serial_in; // [RULE_07]
  wire logic rx_src = ir ? rx_ir_in : rx_pin_in; // [RULE_07]
  wire logic rx_sel = loop ? tx_serial_in : rx_src; // [RULE_10]

  // Resume on any character
  wire logic xany = modem_line_control_register_r[ULMC_MLC_XANY];
  wire logic resume = xany && tx_halted_in && rx_char_in; // [RULE_08]
  wire logic store = rx_char_in && !(rx_is_flow_char_in && rx_swflow_en_in); // [RULE_09]

  // Modem outputs and status
  wire logic rts_bit = modem_line_control_register_r[ULMC_MLC_RTS];
  wire logic dtr_bit = modem_line_control_register_r[ULMC_MLC_DTR];
  wire logic auto_rts = enhanced_feature_register_r[ULMC_ENHF_ARTS];
  wire logic rts_drv = auto_rts ? auto_rts_level_in : ~rts_bit; // [RULE_13] [RULE_14]
  wire logic rts_pin = loop ? 1'b1 : rts_drv; // [RULE_10]
  wire logic dtr_pin = (loop || !dtr_pin_sel_in) ? 1'b1 : ~dtr_bit; // [RULE_15]
  wire logic [3:0] st_in = loop ? {aux2, aux1, dtr_bit, rts_bit} // [RULE_10] [RULE_11]
    : {~cd_n_in, ~ri_n_in, ~dsr_n_in, ~cts_n_in};
  wire logic [7:0] stat_nxt = {st_in, 4'h0};

  // Read mux
  wire logic bank_alt = aux1 && !loop; // [RULE_12]
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr_in)
      ULMC_OFS_LFR: rd_mux = line_format_register_r;
      ULMC_OFS_ENHF: rd_mux = ebank ? enhanced_feature_register_r : 8'h00;
      ULMC_OFS_MLC: rd_mux = bank_bit ? 8'h00 : modem_line_control_register_r; // [RULE_17]
      ULMC_OFS_STAT: rd_mux = (bank_bit || bank_alt) ? 8'h00 : stat_nxt;
      ULMC_OFS_SCR: rd_mux = (bank_bit || bank_alt) ? 8'h00 : scratch_register_r;
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data holds until the next read
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_mux;
    end
  end

  // Serial lines idle high
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tx_pin_out <= 1'b1;
    end else begin
      tx_pin_out <= loop ? 1'b1 : tx_line; // [RULE_10]
    end
  end
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rx_serial_out <= 1'b1;
    end else begin
      rx_serial_out <= rx_sel;
    end
  end

  // Frame format to the transmitter
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      parity_en_out <= 1'b0;
    end else begin
      parity_en_out <= pen; // [RULE_03]
    end
  end
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      parity_bit_out <= 1'b0;
    end else begin
      parity_bit_out <= par_bit;
    end
  end
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      data_bits_out <= 4'h5;
    end else begin
      data_bits_out <= nbits;
    end
  end
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      stop_halves_out <= 3'h2;
    end else begin
      stop_halves_out <= halves;
    end
  end

  // Flow control strobes
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tx_resume_out <= 1'b0;
    end else begin
      tx_resume_out <= resume;
    end
  end
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rx_store_out <= 1'b0;
    end else begin
      rx_store_out <= store;
    end
  end

  // Modem pins inactive high after reset
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rts_n_out <= 1'b1;
    end else begin
      rts_n_out <= rts_pin;
    end
  end
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      dtr_n_out <= 1'b1;
    end else begin
      dtr_n_out <= dtr_pin;
    end
  end
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      modem_status_out <= 8'h00;
    end else begin
      modem_status_out <= stat_nxt;
    end
  end

  // Mode levels
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ir_mode_out <= 1'b0;
      loopback_out <= 1'b0;
      thresh_bank_out <= 1'b0;
    end else begin
      ir_mode_out <= ir;
      loopback_out <= loop;
      thresh_bank_out <= bank_alt;
    end
  end
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      enh_enable_out <= 1'b0;
      sleep_allow_out <= 1'b0;
    end else begin
      enh_enable_out <= enh;
      sleep_allow_out <= enh; // [RULE_18]
    end
  end
endmodule : ulmc_line_modem_ctrl

// File: verif/ulmc_modem_model.sv
/* Far-side modem model: echoes the handshake lines, drives ring, carrier and line.
   Assumes the bench sets the ring, carrier and line levels. */
`timescale 1ns/1ps
module ulmc_modem_model (
  // From the bridge
  input wire logic rts_n_in,
  input wire logic dtr_n_in,
  // From the bench
  input wire logic [1:0] ring_cd_n_in,
  input wire logic line_in,
  // To the bridge
  output logic cts_n_out,
  output logic dsr_n_out,
  output logic ri_n_out,
  output logic cd_n_out,
  output logic rx_pin_out,
  output logic rx_ir_out
);
  assign cts_n_out = rts_n_in;
  assign dsr_n_out = dtr_n_in;
  assign {ri_n_out, cd_n_out} = ring_cd_n_in;
  assign rx_pin_out = line_in;
  // Infrared decoder output is the inverse of the line
  assign rx_ir_out = ~line_in;
endmodule : ulmc_modem_model

// File: verif/ulmc_checker.sv
/* Port checker for the line format and modem control block.
   Assumes binding to the top module, one clock, synchronous reset. */
`timescale 1ns/1ps
module ulmc_checker (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic tx_serial_in,
  input wire logic rx_pin_in,
  input wire logic tx_halted_in,
  input wire logic rx_char_in,
  input wire logic rx_is_flow_char_in,
  input wire logic rx_swflow_en_in,
  input wire logic cts_n_in,
  input wire logic dsr_n_in,
  input wire logic ri_n_in,
  input wire logic cd_n_in,
  input wire logic dtr_pin_sel_in,
  input wire logic tx_pin_out,
  input wire logic rts_n_out,
  input wire logic dtr_n_out,
  input wire logic [7:0] modem_status_out,
  input wire logic rx_serial_out,
  input wire logic tx_resume_out,
  input wire logic rx_store_out,
  input wire logic loopback_out,
  input wire logic thresh_bank_out,
  input wire logic ir_mode_out
);
  logic live_r;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // Past values valid only one edge after reset
  always_ff @(posedge clk_in) live_r <= !reset_in;
  AST_LOOP_PINS: assert property (loopback_out |-> rts_n_out && dtr_n_out && tx_pin_out)
    else $error("pins not idle in loopback");
  AST_LOOP_RX: assert property (live_r && loopback_out && $past(loopback_out)
    |-> rx_serial_out == $past(tx_serial_in)) else $error("loopback receive wrong");
  AST_LINE_RX: assert property (live_r && !(loopback_out || ir_mode_out)
    && $past(!(loopback_out || ir_mode_out)) |-> rx_serial_out == $past(rx_pin_in))
    else $error("line receive wrong");
  AST_BANK: assert property (thresh_bank_out |-> !loopback_out)
    else $error("bank select in loopback");
  AST_RESUME: assert property (live_r && tx_resume_out |-> $past(rx_char_in && tx_halted_in))
    else $error("resume without cause");
  AST_STORE: assert property (live_r |-> rx_store_out ==
    $past(rx_char_in && !(rx_is_flow_char_in && rx_swflow_en_in))) else $error("store wrong");
  AST_STATUS: assert property (live_r && !loopback_out && $past(!loopback_out) |->
    modem_status_out == {~$past({cd_n_in, ri_n_in, dsr_n_in, cts_n_in}), 4'h0})
    else $error("status wrong");
  AST_DTR_OFF: assert property (live_r && $past(!dtr_pin_sel_in) |-> dtr_n_out)
    else $error("terminal ready driven while unselected");
  cover property (loopback_out);
  cover property (tx_resume_out);
  cover property (thresh_bank_out);
endmodule : ulmc_checker
bind ulmc_line_modem_ctrl ulmc_checker chk_u (.clk_in(clk_in), .reset_in(reset_in),
  .tx_serial_in(tx_serial_in), .rx_pin_in(rx_pin_in), .tx_halted_in(tx_halted_in),
  .rx_char_in(rx_char_in), .rx_is_flow_char_in(rx_is_flow_char_in),
  .rx_swflow_en_in(rx_swflow_en_in), .cts_n_in(cts_n_in), .dsr_n_in(dsr_n_in),
  .ri_n_in(ri_n_in), .cd_n_in(cd_n_in), .dtr_pin_sel_in(dtr_pin_sel_in),
  .tx_pin_out(tx_pin_out), .rts_n_out(rts_n_out), .dtr_n_out(dtr_n_out),
  .modem_status_out(modem_status_out), .rx_serial_out(rx_serial_out),
  .tx_resume_out(tx_resume_out), .rx_store_out(rx_store_out), .loopback_out(loopback_out),
  .thresh_bank_out(thresh_bank_out), .ir_mode_out(ir_mode_out));

// File: verif/testbench.sv
/* Register-call bench for the line format and modem control block.
   Assumes the modem model on the far side and a 50 MHz clock. */
`timescale 1ns/1ps
module testbench;
  import ulmc_pkg::*;
  logic clk_in = 1'h0, reset_in = 1'h1, reg_wr_in = 1'h0, reg_rd_in = 1'h0, line = 1'h1;
  logic [2:0] reg_addr_in = 3'h0, stop_halves_out;
  logic [7:0] reg_wdata_in = 8'h00, tx_data_in = 8'h5b, reg_rdata_out, modem_status_out, m;
  logic tx_serial_in = 1'h1, tx_halted_in = 1'h0, rx_char_in = 1'h0, rx_is_flow_char_in = 1'h0;
  logic rx_swflow_en_in = 1'h0, auto_rts_level_in = 1'h0, dtr_pin_sel_in = 1'h0;
  logic [1:0] ring_cd = 2'h3;
  logic [3:0] data_bits_out;
  logic tx_pin_out, parity_en_out, parity_bit_out, baud_tick_out, rx_pin_in, rx_ir_in;
  logic rx_serial_out, tx_resume_out, rx_store_out, cts_n_in, dsr_n_in, ri_n_in, cd_n_in;
  logic rts_n_out, dtr_n_out, ir_mode_out, loopback_out, thresh_bank_out, enh_enable_out;
  logic sleep_allow_out;
  logic tx_ir_in = 1'h0;
  int mismatches = 0, n_compared = 0, t;
  always #10 clk_in = ~clk_in;
  ulmc_line_modem_ctrl dut_u (.clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .tx_data_in(tx_data_in), .tx_serial_in(tx_serial_in),
    .tx_ir_in(tx_ir_in), .tx_pin_out(tx_pin_out), .parity_en_out(parity_en_out),
    .parity_bit_out(parity_bit_out), .data_bits_out(data_bits_out),
    .stop_halves_out(stop_halves_out), .baud_tick_out(baud_tick_out), .rx_pin_in(rx_pin_in),
    .rx_ir_in(rx_ir_in), .rx_serial_out(rx_serial_out), .tx_halted_in(tx_halted_in),
    .rx_char_in(rx_char_in), .rx_is_flow_char_in(rx_is_flow_char_in),
    .rx_swflow_en_in(rx_swflow_en_in), .auto_rts_level_in(auto_rts_level_in),
    .tx_resume_out(tx_resume_out), .rx_store_out(rx_store_out), .cts_n_in(cts_n_in),
    .dsr_n_in(dsr_n_in), .ri_n_in(ri_n_in), .cd_n_in(cd_n_in), .dtr_pin_sel_in(dtr_pin_sel_in),
    .rts_n_out(rts_n_out), .dtr_n_out(dtr_n_out), .modem_status_out(modem_status_out),
    .ir_mode_out(ir_mode_out), .loopback_out(loopback_out), .thresh_bank_out(thresh_bank_out),
    .enh_enable_out(enh_enable_out), .sleep_allow_out(sleep_allow_out));
  ulmc_modem_model far_u (.rts_n_in(rts_n_out), .dtr_n_in(dtr_n_out), .ring_cd_n_in(ring_cd),
    .line_in(line), .cts_n_out(cts_n_in), .dsr_n_out(dsr_n_in), .ri_n_out(ri_n_in),
    .cd_n_out(cd_n_in), .rx_pin_out(rx_pin_in), .rx_ir_out(rx_ir_in));
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask : chk
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in) #1;
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'h1;
    @(posedge clk_in) #1;
    reg_wr_in = 1'h0;
    repeat (2) @(posedge clk_in) #1;
  endtask : wr
  task rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_in) #1;
    reg_addr_in = a;
    reg_rd_in = 1'h1;
    @(posedge clk_in) #1;
    reg_rd_in = 1'h0;
    chk("rdata", reg_rdata_out, e);
  endtask : rd
  task ticks(input int e);
    t = 0;
    repeat (8) begin
      @(posedge clk_in) #1;
      t += baud_tick_out;
    end
    chk("ticks", 8'(t), 8'(e));
  endtask : ticks
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge clk_in) #1;
    reset_in = 1'h0;
    rd(ULMC_OFS_LFR, ULMC_LFR_RESET);
    rd(ULMC_OFS_MLC, 8'h00);
    for (int i = 0; i < 64; i++) begin
      wr(ULMC_OFS_LFR, 8'(i));
      m = tx_data_in & (8'hff >> (2'h3 - i[1:0]));
      chk("pen", parity_en_out, i[3]);
      chk("bits", data_bits_out, 4'h5 + i[1:0]);
      chk("stop", stop_halves_out, i[2] ? (i[1:0] == 2'h0 ? 3'h3 : 3'h4) : 3'h2);
      if (i[3])
        chk("par", parity_bit_out, i[5] ? 1'(~i[4]) : 1'(~(i[4] ^ (^m))));
    end
    wr(ULMC_OFS_LFR, 8'h03);
    wr(ULMC_OFS_SCR, 8'ha5);
    rd(ULMC_OFS_SCR, 8'ha5);
    wr(ULMC_OFS_MLC, 8'hff);
    rd(ULMC_OFS_MLC, 8'h13);
    chk("status", modem_status_out, 8'h30);
    tx_serial_in = 1'h0;
    ticks(8);
    chk("rx", rx_serial_out, 1'h0);
    chk("txpin", tx_pin_out, 1'h1);
    wr(ULMC_OFS_LFR, ULMC_LFR_EBANK_KEY);
    wr(ULMC_OFS_ENHF, 8'h10);
    wr(ULMC_OFS_MLC, 8'h00);
    chk("enh", enh_enable_out, 1'h1);
    chk("sleep", sleep_allow_out, 1'h1);
    wr(ULMC_OFS_LFR, 8'h03);
    rd(ULMC_OFS_MLC, 8'h13);
    wr(ULMC_OFS_MLC, 8'hff);
    chk("status", modem_status_out, 8'hf0);
    ticks(2);
    chk("ir", ir_mode_out, 1'h1);
    wr(ULMC_OFS_MLC, 8'h04);
    chk("bank", thresh_bank_out, 1'h1);
    rd(ULMC_OFS_SCR, 8'h00);
    dtr_pin_sel_in = 1'h1;
    ring_cd = 2'h0;
    tx_ir_in = 1'h1;
    wr(ULMC_OFS_MLC, 8'h43);
    chk("rts", rts_n_out, 1'h0);
    chk("dtr", dtr_n_out, 1'h0);
    chk("txpin", tx_pin_out, 1'h1);
    chk("status", modem_status_out, 8'hf0);
    line = 1'h0;
    ticks(8);
    chk("rx", rx_serial_out, 1'h1);
    wr(ULMC_OFS_MLC, 8'h20);
    chk("txpin", tx_pin_out, 1'h0);
    tx_halted_in = 1'h1;
    rx_swflow_en_in = 1'h1;
    rx_is_flow_char_in = 1'h1;
    rx_char_in = 1'h1;
    @(posedge clk_in) #1;
    rx_char_in = 1'h0;
    chk("resume", tx_resume_out, 1'h1);
    chk("store", rx_store_out, 1'h0);
    @(posedge clk_in) #1;
    rx_swflow_en_in = 1'h0;
    rx_char_in = 1'h1;
    @(posedge clk_in) #1;
    rx_char_in = 1'h0;
    chk("store", rx_store_out, 1'h1);
    wr(ULMC_OFS_LFR, ULMC_LFR_EBANK_KEY);
    wr(ULMC_OFS_ENHF, 8'h50);
    wr(ULMC_OFS_LFR, 8'h03);
    wr(ULMC_OFS_MLC, 8'h20);
    chk("rts", rts_n_out, 1'h0);
    auto_rts_level_in = 1'h1;
    repeat (2) @(posedge clk_in) #1;
    chk("rts", rts_n_out, 1'h1);
    test_done();
  end
endmodule : testbench
